// >>> logic/wdu_regs.vh
// register offsets, field positions, reset values and timing counts
`ifndef WDU_REGS_VH
`define WDU_REGS_VH

// register byte offsets on the apb window
`define WDU_OFF_CTRL     8'h00
`define WDU_OFF_RELOAD   8'h04
`define WDU_OFF_WINDOW   8'h08
`define WDU_OFF_COUNT    8'h0c
`define WDU_OFF_KICK     8'h10
`define WDU_OFF_STATUS   8'h14
`define WDU_OFF_MASK     8'h18

// control register fields
`define WDU_CTRL_EN      0
`define WDU_CTRL_RSTSEL  1
`define WDU_CTRL_DIV_LSB 2
`define WDU_CTRL_DIV_MSB 4
`define WDU_CTRL_W       6

// status and mask fields
`define WDU_ST_WIN       0
`define WDU_ST_UNF       1
`define WDU_ST_W         2

// reset values
`define WDU_CTRL_RST     6'h02
`define WDU_RELOAD_RST   24'hffffff
`define WDU_WINDOW_RST   24'h000000
`define WDU_MASK_RST     2'h0

// timing: system clock and watchdog oscillator rates in hz
`define WDU_PCLK_HZ      20000000
`define WDU_RC_HZ        40000
`define WDU_RC_CYCLES    (`WDU_PCLK_HZ / `WDU_RC_HZ)

`endif

// >>> logic/wdu_tick_gen.v
// count clock generator: oscillator tick then selectable divider
`timescale 1ns/1ns
`default_nettype none

`include "wdu_regs.vh"

module wdu_tick_gen
#(
  parameter integer RC_DIV = `WDU_RC_CYCLES // pclk cycles per osc period
)
(
  input  wire       pclk,    // system clock
  input  wire       presetn, // async reset, active low
  input  wire       run,     // counting enabled
  input  wire [2:0] div_sel, // divide oscillator by 2**div_sel
  output reg        tick     // one-cycle count clock pulse
);

  reg  [15:0] rc_cnt_q;  // oscillator period counter
  reg  [7:0]  div_cnt_q; // divider stage counter
  wire        rc_tick;   // one oscillator period elapsed
  wire [7:0]  div_mask;  // low bits that must all be one

  assign rc_tick  = (rc_cnt_q == RC_DIV[15:0] - 16'h0001);
  assign div_mask = (8'h01 << div_sel) - 8'h01;

  // oscillator stand-in: the watchdog oscillator is modelled as a
  // fixed division of pclk, which must stay on in deep sleep
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rc_cnt_q  <= 16'h0000;
      div_cnt_q <= 8'h00;
      tick      <= 1'b0;
    end
    else if (!run)
    begin
      // stopped: restart cleanly so the first period is full length
      rc_cnt_q  <= 16'h0000;
      div_cnt_q <= 8'h00;
      tick      <= 1'b0;
    end
    else
    begin
      rc_cnt_q <= rc_tick ? 16'h0000 : rc_cnt_q + 16'h0001;
      if (rc_tick)
        div_cnt_q <= div_cnt_q + 8'h01;
      tick <= rc_tick & ((div_cnt_q & div_mask) == div_mask);
    end
  end

endmodule // wdu_tick_gen

`default_nettype wire

// >>> logic/wdu_watchdog.v
// watchdog unit top: apb registers, 24-bit down counter, events
`timescale 1ns/1ns
`default_nettype none

`include "wdu_regs.vh"

module wdu_watchdog
#(
  parameter integer RC_DIV = `WDU_RC_CYCLES // pclk cycles per osc period
)
(
  input  wire        pclk,       // apb clock, 20 mhz
  input  wire        presetn,    // async reset, active low
  input  wire        psel,       // apb select
  input  wire        penable,    // apb access phase
  input  wire        pwrite,     // apb direction, 1 = write
  input  wire [7:0]  paddr,      // apb byte address
  input  wire [31:0] pwdata,     // apb write data
  output reg  [31:0] prdata,     // apb read data
  output reg         pready,     // apb transfer done
  output reg         pslverr,    // apb error, unmapped address
  input  wire        deep_sleep, // device is in deep sleep
  output reg         irq,        // level interrupt to the core
  output reg         wake_req,   // wake request toward power control
  output reg         rst_req,    // system reset request, sticky
  output reg         ovf_pulse   // one-cycle underflow indication
);

  // software visible state
  reg  [`WDU_CTRL_W-1:0] ctrl_q;   // enable, reset select, divider
  reg  [23:0]            reload_q; // reload_value
  reg  [23:0]            window_q; // window_compare_value
  reg  [23:0]            count_q;  // watchdog_count
  reg  [`WDU_ST_W-1:0]   status_q; // sticky event flags
  reg  [`WDU_ST_W-1:0]   mask_q;   // interrupt enables
  reg                    kick_q;   // reload request waiting for tick

  // bus decode
  wire        access;    // access phase completing this edge
  wire        wr_en;     // write completing this edge
  reg  [31:0] rd_data_d; // read mux
  reg         addr_ok_d; // address maps to a register

  // counter control
  wire        en;        // counting enabled
  wire        rst_sel;   // underflow also requests a system reset
  wire [2:0]  div_sel;   // count_clock_divider setting
  wire        tick;      // count clock pulse
  wire [23:0] count_dec; // count minus one
  wire        unf_ev;    // underflow this cycle
  wire        win_ev;    // window match this cycle
  wire        kick_wr;   // software reload request
  wire [`WDU_ST_W-1:0] ev;  // events by status bit
  wire [`WDU_ST_W-1:0] w1c; // clear strobes by status bit
  wire [`WDU_ST_W-1:0] status_d; // next status
  wire        pend;      // any unmasked status bit

  assign en      = ctrl_q[`WDU_CTRL_EN];
  assign rst_sel = ctrl_q[`WDU_CTRL_RSTSEL];
  assign div_sel = ctrl_q[`WDU_CTRL_DIV_MSB:`WDU_CTRL_DIV_LSB];

  // the access completes at the edge that samples pready high
  assign access  = psel & penable & pready;
  assign wr_en   = access & pwrite;
  assign kick_wr = wr_en & (paddr == `WDU_OFF_KICK);

  // count clock: oscillator period times 2**div_sel
  wdu_tick_gen
  #(
    .RC_DIV (RC_DIV)
  )
  u_tick
  (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (en),
    .div_sel (div_sel),
    .tick    (tick)
  );

  assign count_dec = count_q - 24'h000001;

  // events only happen on a count tick without a pending reload
  assign unf_ev = en & tick & ~kick_q & (count_q == 24'h000000);
  assign win_ev = en & tick & ~kick_q & (count_q != 24'h000000)
                  & (count_dec == window_q);

  assign ev[`WDU_ST_WIN] = win_ev;
  assign ev[`WDU_ST_UNF] = unf_ev;

  // status write clears bits written with one
  assign w1c = (wr_en && paddr == `WDU_OFF_STATUS) ?
               pwdata[`WDU_ST_W-1:0] : {`WDU_ST_W{1'b0}};

  // per flag: a new event wins over a clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < `WDU_ST_W; gi = gi + 1)
    begin : g_status
      assign status_d[gi] = ev[gi] | (status_q[gi] & ~w1c[gi]);
    end
  endgenerate

  // underflow flags status in both modes; the mask picks irq use
  assign pend = |(status_q & mask_q);

  // apb wait state: pready rises one cycle into the access phase
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= psel & penable & ~pready;
  end

  // read mux and address check
  always @*
  begin
    rd_data_d = 32'h00000000;
    addr_ok_d = 1'b1;
    case (paddr)
      `WDU_OFF_CTRL:
        rd_data_d[`WDU_CTRL_W-1:0] = ctrl_q;
      `WDU_OFF_RELOAD:
        rd_data_d[23:0] = reload_q;
      `WDU_OFF_WINDOW:
        rd_data_d[23:0] = window_q;
      `WDU_OFF_COUNT:
        rd_data_d[23:0] = count_q;           // live counter view
      `WDU_OFF_KICK:
        rd_data_d[0] = kick_q;               // reload still pending
      `WDU_OFF_STATUS:
        rd_data_d[`WDU_ST_W-1:0] = status_q;
      `WDU_OFF_MASK:
        rd_data_d[`WDU_ST_W-1:0] = mask_q;
      default:
        addr_ok_d = 1'b0;                    // unmapped, reads zero
    endcase
  end

  // read data and error are launched with pready
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (psel & penable & ~pready)
    begin
      prdata  <= pwrite ? 32'h00000000 : rd_data_d;
      pslverr <= ~addr_ok_d;
    end
    else
    begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
  end

  // configuration registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q   <= `WDU_CTRL_RST;
      reload_q <= `WDU_RELOAD_RST;
      window_q <= `WDU_WINDOW_RST;
      mask_q   <= `WDU_MASK_RST;
    end
    else if (wr_en)
    begin
      case (paddr)
        `WDU_OFF_CTRL:
          ctrl_q <= pwdata[`WDU_CTRL_W-1:0];
        `WDU_OFF_RELOAD:
          reload_q <= pwdata[23:0];
        `WDU_OFF_WINDOW:
          window_q <= pwdata[23:0];
        `WDU_OFF_MASK:
          mask_q <= pwdata[`WDU_ST_W-1:0];
        default:
          ctrl_q <= ctrl_q;                   // others have no store
      endcase
    end
  end

  // reload request: held until the next count tick takes it;
  // a new request in the consuming cycle stays pending
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      kick_q <= 1'b0;
    else if (!en)
      kick_q <= 1'b0;
    else
      kick_q <= kick_wr | (kick_q & ~tick);
  end

  // the down counter; pclk stands for the always-on domain so the
  // count carries on through deep sleep
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_q <= `WDU_RELOAD_RST;
    else if (!en)
      count_q <= reload_q;                    // armed, not counting
    else if (tick)
    begin
      if (kick_q)
        count_q <= reload_q;
      else if (count_q == 24'h000000)
        count_q <= reload_q;
      else
        count_q <= count_dec;
    end
  end

  // sticky status flags
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_q <= {`WDU_ST_W{1'b0}};
    else
      status_q <= status_d;
  end

  // interrupt and wake outputs; the wake path drops the watchdog
  // source in deep sleep, so only the level to the core remains
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq      <= 1'b0;
      wake_req <= 1'b0;
    end
    else
    begin
      irq      <= pend;
      wake_req <= pend & ~deep_sleep;
    end
  end

  // reset request stays up until the system reset comes back here;
  // underflow pulse goes out in either mode
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rst_req   <= 1'b0;
      ovf_pulse <= 1'b0;
    end
    else
    begin
      rst_req   <= rst_req | (unf_ev & rst_sel);
      ovf_pulse <= unf_ev;
    end
  end

endmodule // wdu_watchdog

`default_nettype wire

// >>> dv/wdu_checker.sv
// port assertions for the watchdog unit
`timescale 1ns/1ns
`default_nettype none

module wdu_checker
(
  input wire logic        pclk,       // system clock
  input wire logic        presetn,    // async reset, active low
  input wire logic        psel,       // apb select
  input wire logic        penable,    // apb access phase
  input wire logic [31:0] prdata,     // apb read data
  input wire logic        pready,     // apb transfer done
  input wire logic        pslverr,    // apb error
  input wire logic        deep_sleep, // device asleep
  input wire logic        irq,        // level interrupt
  input wire logic        wake_req,   // wake request
  input wire logic        rst_req,    // sticky reset request
  input wire logic        ovf_pulse   // underflow pulse
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // exactly one wait state after the setup cycle
  AST_READY_WAIT:
    assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not after one wait state");
  AST_READY_ONE:
    assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  AST_ERR_WITH_READY:
    assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_RDATA_IDLE:
    assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside the answer cycle");
  AST_OVF_ONE:
    assert property (ovf_pulse |=> !ovf_pulse)
    else $error("underflow pulse wider than one cycle");
  AST_RST_STICKY:
    assert property (rst_req |=> rst_req)
    else $error("reset request dropped");
  AST_RST_CAUSE:
    assert property ($rose(rst_req) |-> (##[0:1] ovf_pulse) or
                     $past(ovf_pulse))
    else $error("reset request without underflow");
  AST_NO_WAKE_ASLEEP:
    assert property (deep_sleep && $past(deep_sleep) |-> !wake_req)
    else $error("wake request during deep sleep");

  COV_OVF: cover property (ovf_pulse);
  COV_RST: cover property ($rose(rst_req));
  COV_SLEEP_IRQ: cover property (deep_sleep && irq);
endmodule // wdu_checker

bind wdu_watchdog wdu_checker i_chk (.pclk, .presetn, .psel, .penable,
  .prdata, .pready, .pslverr, .deep_sleep, .irq, .wake_req, .rst_req,
  .ovf_pulse);

`default_nettype wire

// >>> dv/wdu_core_model.sv
// processor core model that takes reset and underflow requests
`timescale 1ns/1ns
`default_nettype none

module wdu_core_model
(
  input  wire logic pclk,      // system clock
  input  wire logic presetn,   // async reset, active low
  input  wire logic rst_req,   // reset request from the unit
  input  wire logic ovf_pulse, // underflow pulse
  output var  int   n_ovf,     // underflow pulses seen
  output var  int   n_rst      // reset requests taken
);
  logic rst_seen_q; // last sampled request, for edge detect

  // count pulses and rising requests; a real core would restart here
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      n_ovf      <= 0;
      n_rst      <= 0;
      rst_seen_q <= 1'b0;
    end
    else
    begin
      n_ovf      <= n_ovf + int'(ovf_pulse);
      n_rst      <= n_rst + int'(rst_req && !rst_seen_q);
      rst_seen_q <= rst_req;
    end
  end
endmodule // wdu_core_model

`default_nettype wire

// >>> dv/tb_windowed_watchdog_timer.sv
// self-checking bench for the watchdog unit
`timescale 1ns/1ns
`default_nettype none
`include "wdu_regs.vh"

module tb_windowed_watchdog_timer;
  localparam int RC = 4;       // shortened oscillator period in pclk
  logic        pclk = 1'b0;    // system clock
  logic        presetn = 1'b0; // reset, active low
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;  // apb address
  logic [31:0] pwdata = 32'h0; // apb write data
  logic        deep_sleep = 1'b0; // sleep level
  wire  [31:0] prdata;         // apb read data
  wire         pready, pslverr, irq, wake_req, rst_req, ovf_pulse;
  int          n_rst;          // resets taken by the core model
  int          n_ovf;          // underflows seen by the core model
  int          failures = 0;   // mismatches
  int          n_compared = 0; // comparisons made
  logic [31:0] r;              // last read data
  logic        e;              // last error flag
  int          c;              // cycle count

  wdu_watchdog #(.RC_DIV(RC)) i_dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .deep_sleep,
    .irq, .wake_req, .rst_req, .ovf_pulse);
  wdu_core_model i_core (.pclk, .presetn, .rst_req, .ovf_pulse,
    .n_ovf(n_ovf), .n_rst(n_rst));

  always #25 pclk = ~pclk;

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  // one apb transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // cycles until the next underflow pulse
  task automatic wait_ovf();
    c = 0;
    do
    begin
      @(posedge pclk);
      c++;
    end while (ovf_pulse !== 1'b1 && c < 500);
    if (c >= 500) failures++;
  endtask

  // reset values, unmapped address, read-only count
  task automatic t_regs();
    logic [7:0]  a[6];
    logic [31:0] x[6];
    a = '{`WDU_OFF_CTRL, `WDU_OFF_RELOAD, `WDU_OFF_WINDOW,
          `WDU_OFF_COUNT, `WDU_OFF_STATUS, `WDU_OFF_MASK};
    x = '{`WDU_CTRL_RST, `WDU_RELOAD_RST, `WDU_WINDOW_RST,
          `WDU_RELOAD_RST, 32'h0, `WDU_MASK_RST};
    foreach (a[i])
    begin
      apb(1'b0, a[i], 32'h0);
      chk(r, x[i]);
    end
    apb(1'b0, 8'h1c, 32'h0);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, `WDU_OFF_COUNT, 32'h5);
    apb(1'b0, `WDU_OFF_COUNT, 32'h0);
    chk(r, 32'hffffff);
  endtask

  // periodic interrupt mode, divider 1, running through deep sleep
  task automatic t_periodic();
    apb(1'b1, `WDU_OFF_MASK, 32'h2);
    apb(1'b1, `WDU_OFF_RELOAD, 32'h2);
    apb(1'b0, `WDU_OFF_COUNT, 32'h0);
    chk(r, 32'h2);
    apb(1'b1, `WDU_OFF_WINDOW, 32'h1);
    apb(1'b1, `WDU_OFF_CTRL, 32'h5);
    deep_sleep <= 1'b1;
    wait_ovf();
    wait_ovf();
    chk(c, 3 * RC * 2);
    chk(wake_req, 1'b0);
    chk({irq, rst_req}, 2'b10);
    apb(1'b0, `WDU_OFF_STATUS, 32'h0);
    chk(r, 32'h3);
    chk(n_ovf, 2);
    deep_sleep <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(wake_req, 1'b1);
    apb(1'b1, `WDU_OFF_CTRL, 32'h0);
    apb(1'b1, `WDU_OFF_STATUS, 32'h3);
    apb(1'b0, `WDU_OFF_STATUS, 32'h0);
    chk({r[1:0], irq}, 3'b000);
  endtask

  // a kick reloads the count from the reload value
  task automatic t_kick();
    apb(1'b1, `WDU_OFF_RELOAD, 32'd100);
    apb(1'b1, `WDU_OFF_CTRL, 32'h1);
    repeat (60) @(posedge pclk);
    apb(1'b1, `WDU_OFF_KICK, 32'h1);
    repeat (10) @(posedge pclk);
    apb(1'b0, `WDU_OFF_COUNT, 32'h0);
    chk(r >= 32'd97 && r <= 32'd100, 1'b1);
    apb(1'b1, `WDU_OFF_CTRL, 32'h0);
  endtask

  // reset mode: underflow raises a request that stays
  task automatic t_reset_mode();
    apb(1'b1, `WDU_OFF_RELOAD, 32'h1);
    apb(1'b1, `WDU_OFF_CTRL, 32'h3);
    wait_ovf();
    apb(1'b1, `WDU_OFF_CTRL, 32'h0);
    chk({rst_req, n_rst[1:0]}, 3'b101);
    repeat (3) @(posedge pclk);
    chk(rst_req, 1'b1);
    // the system reset coming back is what drops the request
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({rst_req, irq, n_rst[1:0]}, 4'b0000);
    apb(1'b0, `WDU_OFF_CTRL, 32'h0);
    chk(r, `WDU_CTRL_RST);
  endtask

  task automatic test_done();
    if (failures == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_periodic();
    t_kick();
    t_reset_mode();
    test_done();
  end

  // cut a hang short
  initial
  begin
    #(50 * 4000);
    failures++;
    test_done();
  end
endmodule // tb_windowed_watchdog_timer

`default_nettype wire
